// ### rtl/bpe_pkg.sv
// package for the bit position encoder: register map, control word layout, reset values
package bpe_pkg;

  // register byte offsets
  localparam logic [7:0] BPE_OFS_CMD      = 8'h00;
  localparam logic [7:0] BPE_OFS_CTRL     = 8'h04;
  localparam logic [7:0] BPE_OFS_RESULT   = 8'h08;
  localparam logic [7:0] BPE_OFS_STATUS   = 8'h0c;
  localparam logic [7:0] BPE_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] BPE_OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] BPE_OFS_SRC      = 8'h80;

  // source word store size
  localparam int         BPE_SRC_WORDS    = 32;
  localparam int         BPE_FIELD_WORDS  = 16;

  // command, status and interrupt bit positions
  localparam int         BPE_CMD_GO_BIT   = 0;
  localparam int         BPE_ST_BUSY_BIT  = 0;
  localparam int         BPE_ST_FAULT_BIT = 1;
  localparam int         BPE_EV_DONE_BIT  = 0;
  localparam int         BPE_EV_FAULT_BIT = 1;
  localparam int         BPE_EV_W         = 2;

  // control word digit codes
  localparam logic [3:0] BPE_MODE_16_4    = 4'h0;
  localparam logic [3:0] BPE_MODE_256_8   = 4'h1;
  localparam logic [3:0] BPE_DIR_HIGH     = 4'h0;
  localparam logic [3:0] BPE_DIR_LOW      = 4'h1;
  localparam logic [3:0] BPE_MAX_DIGIT    = 4'h3;
  localparam logic [3:0] BPE_MAX_BYTE     = 4'h1;

  // reset values
  localparam logic [15:0] BPE_CTRL_RST    = 16'h0000;
  localparam logic [15:0] BPE_RESULT_RST  = 16'h0000;
  localparam logic [15:0] BPE_SRC_RST     = 16'h0000;
  localparam logic [1:0]  BPE_MASK_RST    = 2'h0;

  // control word as four digits, most significant first
  typedef struct packed {
    logic [3:0] mode;
    logic [3:0] dir;
    logic [3:0] cnt;
    logic [3:0] first;
  } bpe_ctrl_t;

  // apb request fields that travel together
  typedef struct packed {
    logic [7:0]  addr;
    logic        write;
    logic [31:0] wdata;
  } bpe_apb_req_t;

endpackage

// ### rtl/bpe_encoder.sv
// bit position encoder with apb register access and interrupt
//
// What this block does
// - control top digit 0 selects 16-to-4, 1 selects 256-to-8 encoding.
// - second digit 0 encodes highest set bit, 1 encodes lowest set bit.
// - 16-to-4 mode encodes up to four words, one 4-bit position each.
// - result digits fill upward from the start digit, wrapping past digit 3.
// - 256-to-8 mode treats sixteen words as one field, one or two fields.
// - two bytes written low first; starting at byte 1 wraps to byte 0.
// - any all-zero source word to be encoded raises the fault flag.
// - out-of-range control digit raises fault; clean conversion clears it.
// - control word gives mode, direction, count and start position.
`timescale 1ns/10ps

module bpe_encoder
  import bpe_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  typedef enum logic [1:0] {BPE_IDLE, BPE_RUN, BPE_DONE} bpe_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // lowest hit wins when low is set, else the last (highest) hit wins
  function automatic logic [3:0] bpe_enc16(input logic [15:0] w, input logic low);
    logic [3:0] p;
    logic       hit;
    p   = '0;
    hit = 1'b0;
    for (int b = 0; b < 16; b++) begin
      if (w[b] && (!low || !hit)) begin
        p   = 4'(b);
        hit = 1'b1;
      end
    end
    return p;
  endfunction

  function automatic logic [7:0] bpe_enc256(input logic [255:0] f, input logic low);
    logic [7:0] p;
    logic       hit;
    p   = '0;
    hit = 1'b0;
    for (int b = 0; b < 256; b++) begin
      if (f[b] && (!low || !hit)) begin
        p   = 8'(b);
        hit = 1'b1;
      end
    end
    return p;
  endfunction

  function automatic logic bpe_ctrl_ok(input bpe_ctrl_t c);
    logic ok;
    ok = 1'b0;
    if (c.dir == BPE_DIR_HIGH || c.dir == BPE_DIR_LOW) begin
      if (c.mode == BPE_MODE_16_4)
        ok = (c.cnt <= BPE_MAX_DIGIT) && (c.first <= BPE_MAX_DIGIT);
      else if (c.mode == BPE_MODE_256_8)
        ok = (c.cnt <= BPE_MAX_BYTE) && (c.first <= BPE_MAX_BYTE);
    end
    return ok;
  endfunction

  // one place for the fixed-register compares of the write decode
  function automatic logic bpe_reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    return (a == ofs);
  endfunction

  // a zero word has no set bit whose position could be reported
  function automatic logic bpe_word_zero(input logic [15:0] w);
    return (w == 16'h0000);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // storage and state

  logic [15:0]         src_r [BPE_SRC_WORDS];
  bpe_ctrl_t           ctrl_r;
  logic [15:0]         result_r;
  logic [15:0]         shadow_r;
  logic                fault_flag_r;
  logic [BPE_EV_W-1:0] irq_stat_r;
  logic [BPE_EV_W-1:0] irq_mask_r;
  logic [31:0]         prdata_r;
  bpe_state_t          state_r;
  logic [1:0]          idx_r;
  logic                zero_seen_r;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  bpe_apb_req_t req;
  logic         setup_ph;
  logic         access_ph;
  logic         wr_acc;
  logic         src_hit;
  logic [4:0]   src_idx;
  logic         mapped;
  logic         busy;
  logic         wr_cmd;
  logic         wr_ctrl;
  logic         wr_result;
  logic         wr_stat;
  logic         wr_mask;
  logic         wr_src;
  logic         rd_src;

  assign req       = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign src_hit   = req.addr[7];
  assign src_idx   = req.addr[6:2];
  assign busy      = (state_r != BPE_IDLE);
  assign mapped    = (req.addr[1:0] == 2'h0) &&
                     (src_hit || req.addr <= BPE_OFS_IRQ_MASK);
  // read data is captured in the setup cycle, so the access cycle answers at once
  assign pready    = 1'b1;
  assign pslverr   = access_ph && !mapped;
  assign prdata    = prdata_r;
  assign wr_acc    = access_ph && req.write && mapped;
  assign irq       = |(irq_stat_r & irq_mask_r);

  // busy guards the operands, control and result; mask and status stay writable mid-conversion
  assign wr_cmd    = wr_acc && bpe_reg_hit(req.addr, BPE_OFS_CMD);
  assign wr_ctrl   = wr_acc && bpe_reg_hit(req.addr, BPE_OFS_CTRL) && !busy;
  assign wr_result = wr_acc && bpe_reg_hit(req.addr, BPE_OFS_RESULT) && !busy;
  assign wr_stat   = wr_acc && bpe_reg_hit(req.addr, BPE_OFS_IRQ_STAT);
  assign wr_mask   = wr_acc && bpe_reg_hit(req.addr, BPE_OFS_IRQ_MASK);
  assign wr_src    = wr_acc && src_hit && !busy;
  // a misaligned source address is a hole and must read as zero
  assign rd_src    = src_hit && (req.addr[1:0] == 2'h0);

  logic go;
  assign go = wr_cmd && req.wdata[BPE_CMD_GO_BIT] && !busy;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph && !req.write) begin
      prdata_r <= 32'h0000_0000;
      if (rd_src) begin
        prdata_r[15:0] <= src_r[src_idx];
      end else begin
        case (req.addr)
          BPE_OFS_CTRL:     prdata_r[15:0] <= ctrl_r;
          BPE_OFS_RESULT:   prdata_r[15:0] <= result_r;
          BPE_OFS_STATUS: begin
            prdata_r[BPE_ST_BUSY_BIT]  <= busy;
            prdata_r[BPE_ST_FAULT_BIT] <= fault_flag_r;
          end
          BPE_OFS_IRQ_STAT: prdata_r[BPE_EV_W-1:0] <= irq_stat_r;
          BPE_OFS_IRQ_MASK: prdata_r[BPE_EV_W-1:0] <= irq_mask_r;
          default:          prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software-written registers; operands and control are frozen while busy

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < BPE_SRC_WORDS; i++) begin
        src_r[i] <= BPE_SRC_RST;
      end
    end else if (wr_src) begin
      src_r[src_idx] <= req.wdata[15:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= BPE_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= req.wdata[15:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_r <= BPE_MASK_RST;
    end else if (wr_mask) begin
      irq_mask_r <= req.wdata[BPE_EV_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-step encode of the current word or field

  logic [255:0] field;
  logic         field_zero;
  logic [4:0]   word_sel;
  logic [3:0]   pos4;
  logic [7:0]   pos8;
  logic [1:0]   digit_sel;
  logic         byte_sel;
  logic         low_scan;
  logic         mode_wide;
  logic         last_step;
  logic [15:0]  shadow_nxt;

  assign mode_wide = (ctrl_r.mode == BPE_MODE_256_8);
  assign low_scan  = (ctrl_r.dir == BPE_DIR_LOW);
  assign word_sel  = {3'h0, idx_r};

  always_comb begin
    field      = '0;
    field_zero = 1'b0;
    if (mode_wide) begin
      // sixteen words starting at field idx form one 256-bit range
      for (int w = 0; w < BPE_FIELD_WORDS; w++) begin
        field[w*16 +: 16] = src_r[idx_r[0] * BPE_FIELD_WORDS + w];
        if (bpe_word_zero(src_r[idx_r[0] * BPE_FIELD_WORDS + w])) begin
          field_zero = 1'b1;
        end
      end
    end else begin
      field[15:0] = src_r[word_sel];
      field_zero  = bpe_word_zero(src_r[word_sel]);
    end
  end

  assign pos4      = bpe_enc16(field[15:0], low_scan);
  assign pos8      = bpe_enc256(field, low_scan);
  // start digit in the lowest digit, count minus one in the next
  assign digit_sel = 2'(ctrl_r.first) + idx_r;
  assign byte_sel  = ctrl_r.first[0] ^ idx_r[0];
  assign last_step = (idx_r == 2'(ctrl_r.cnt));

  always_comb begin
    shadow_nxt = shadow_r;
    if (mode_wide) begin
      shadow_nxt[byte_sel*8 +: 8] = pos8;
    end else begin
      shadow_nxt[digit_sel*4 +: 4] = pos4;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  // one word or field per clock: count plus one steps, then a commit cycle

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r     <= BPE_IDLE;
      idx_r       <= 2'h0;
      zero_seen_r <= 1'b0;
      shadow_r    <= BPE_RESULT_RST;
    end else begin
      case (state_r)
        BPE_IDLE: begin
          if (go && bpe_ctrl_ok(ctrl_r)) begin
            state_r     <= BPE_RUN;
            idx_r       <= 2'h0;
            zero_seen_r <= 1'b0;
            shadow_r    <= result_r;  // untouched digits keep their value
          end
        end
        BPE_RUN: begin
          shadow_r    <= shadow_nxt;
          zero_seen_r <= zero_seen_r | field_zero;
          idx_r       <= idx_r + 2'h1;
          if (last_step) begin
            state_r <= BPE_DONE;
          end
        end
        BPE_DONE: begin
          state_r <= BPE_IDLE;
        end
        default: begin
          state_r <= BPE_IDLE;
        end
      endcase
    end
  end

  // a bad control word finishes at once; otherwise the result commits only if
  // no zero word was met, so software never sees a half-written result
  logic ctrl_bad;
  logic run_done;
  logic conv_end;
  assign ctrl_bad = go && !bpe_ctrl_ok(ctrl_r);
  assign run_done = (state_r == BPE_DONE);
  assign conv_end = ctrl_bad || run_done;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      result_r <= BPE_RESULT_RST;
    end else if (run_done && !zero_seen_r) begin
      result_r <= shadow_r;
    end else if (wr_result) begin
      result_r <= req.wdata[15:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fault_flag_r <= 1'b0;
    end else if (ctrl_bad) begin
      fault_flag_r <= 1'b1;
    end else if (run_done) begin
      fault_flag_r <= zero_seen_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky events, write one to clear; a new event beats a same-cycle clear

  logic [BPE_EV_W-1:0] ev;
  logic [BPE_EV_W-1:0] w1c;

  always_comb begin
    ev                   = '0;
    ev[BPE_EV_DONE_BIT]  = conv_end;
    ev[BPE_EV_FAULT_BIT] = ctrl_bad || (run_done && zero_seen_r);
  end

  assign w1c = wr_stat ? req.wdata[BPE_EV_W-1:0] : '0;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~w1c) | ev;
    end
  end

endmodule

// ### tb/bpe_encoder_checker.sv
// assertions on the encoder apb port and interrupt line
`timescale 1ns/10ps
module bpe_encoder_checker
  import bpe_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq
);
  logic acc;
  logic hole;
  assign acc = psel & penable;
  // gap below the source store and misaligned bytes answer with an error
  assign hole = (paddr[1:0] != 2'h0) || (paddr >= 8'h18 && paddr < BPE_OFS_SRC);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_hole: assert property (acc && hole |-> pslverr) else $error("no slverr");
  a_err_map: assert property (acc && !hole |-> !pslverr) else $error("bad slverr");
  a_err_idle: assert property (!psel |-> !pslverr) else $error("idle slverr");
  a_mask_off: assert property (acc && pwrite && paddr == BPE_OFS_IRQ_MASK &&
    pwdata[1:0] == 2'h0 |=> !irq [*2]) else $error("irq while masked");
  a_cmd_read: assert property (acc && !pwrite && paddr == BPE_OFS_CMD |-> prdata == 32'h0)
    else $error("cmd reads nonzero");
  a_hole_read: assert property (acc && !pwrite && hole |-> prdata == 32'h0)
    else $error("hole reads nonzero");
  a_status_upper: assert property (acc && !pwrite && paddr == BPE_OFS_STATUS |->
    prdata[31:2] == 30'h0) else $error("status upper bits");
  c_go: cover property (acc && pwrite && paddr == BPE_OFS_CMD && pwdata[0]);
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (acc && pslverr);
endmodule

bind bpe_encoder bpe_encoder_checker i_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq));

// ### tb/bpe_src_model.sv
// operand supplier model: the data area the sequencer hands to the encoder
`timescale 1ns/10ps
module bpe_src_model
  import bpe_pkg::*;
(
  output logic [BPE_SRC_WORDS-1:0][15:0] words
);
  // thirty-two contiguous words of one area, none zero so every field encodes
  always_comb begin
    for (int i = 0; i < BPE_SRC_WORDS; i++) begin
      words[i] = 16'h0100;
    end
    words[0]  = 16'h8001;
    words[1]  = 16'h0010;
    words[2]  = 16'h0300;
    words[3]  = 16'h0002;
    words[16] = 16'h0020;
    words[31] = 16'h4000;
  end
endmodule

// ### tb/tb_bpe_encoder.sv
// self-checking bench for the bit position encoder
`timescale 1ns/10ps
module tb_bpe_encoder
  import bpe_pkg::*;
();
  logic                           clk_sys, rst_b, psel, penable, pwrite;
  logic [7:0]                     paddr;
  logic [31:0]                    pwdata, prdata, rd_val;
  logic                           pready, pslverr, irq, rd_err;
  logic [BPE_SRC_WORDS-1:0][15:0] sup_words;
  logic [7:0]                     regs [7];
  logic [15:0]                    bad [6];
  int                             num_errors = 0;
  int                             n_compared = 0;

  bpe_encoder i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq));
  bpe_src_model i_src (.words(sup_words));

  task automatic finish_test();
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held from setup until pready is seen high at an edge
  task automatic xfer(input bpe_apb_req_t req);
    @(posedge clk_sys);
    psel <= 1'b1;
    {paddr, pwrite, pwdata} <= req;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer('{a, 1'b1, d});
  endtask

  task automatic rd(input logic [7:0] a);
    xfer('{a, 1'b0, 32'h0});
  endtask

  task automatic chk_irq(input logic exp);
    @(negedge clk_sys);
    check({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic conv(input logic [15:0] ctrl, input logic [15:0] res, input logic flt);
    int n;
    wr(BPE_OFS_CTRL, {16'h0, ctrl});
    wr(BPE_OFS_CMD, 32'h1);
    n = 0;
    do begin
      rd(BPE_OFS_STATUS);
      n++;
    end while (rd_val[BPE_ST_BUSY_BIT] !== 1'b0 && n < 20);
    check({31'h0, rd_val[BPE_ST_FAULT_BIT]}, {31'h0, flt});
    rd(BPE_OFS_RESULT);
    check(rd_val, {16'h0, res});
    rd(BPE_OFS_STATUS);
    check(rd_val, {30'h0, flt, 1'b0});
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    finish_test();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst_b = 1'b0;
    regs = '{BPE_OFS_CMD, BPE_OFS_CTRL, BPE_OFS_RESULT, BPE_OFS_STATUS, BPE_OFS_IRQ_STAT,
             BPE_OFS_IRQ_MASK, BPE_OFS_SRC};
    bad = '{16'h2000, 16'h0200, 16'h0040, 16'h0004, 16'h1020, 16'h1002};
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    foreach (regs[i]) begin
      rd(regs[i]);
      check(rd_val, 32'h0);
    end
    for (int i = 0; i < BPE_SRC_WORDS; i++) begin
      wr(8'(BPE_OFS_SRC + 4 * i), {16'h0, sup_words[i]});
    end
    conv(16'h0031, 16'h94f1, 1'b0);
    conv(16'h0131, 16'h8401, 1'b0);
    wr(BPE_OFS_RESULT, 32'habcd);
    conv(16'h0013, 16'hfbc4, 1'b0);
    conv(16'h1011, 16'hf8fe, 1'b0);
    conv(16'h1110, 16'h0500, 1'b0);
    wr(BPE_OFS_SRC + 8'h08, 32'h0);
    conv(16'h0030, 16'h0500, 1'b1);
    conv(16'h0000, 16'h050f, 1'b0);
    conv(16'h1000, 16'h050f, 1'b1);
    foreach (bad[i]) begin
      conv(bad[i], 16'h050f, 1'b1);
    end
    wr(BPE_OFS_SRC + 8'h08, 32'h0300);
    conv(16'h1001, 16'hf80f, 1'b0);
    // control writes during a conversion are dropped
    wr(BPE_OFS_CTRL, 32'h0033);
    wr(BPE_OFS_CMD, 32'h1);
    wr(BPE_OFS_CTRL, 32'h0);
    repeat (10) @(posedge clk_sys);
    rd(BPE_OFS_CTRL);
    check(rd_val, 32'h0033);
    rd(BPE_OFS_RESULT);
    check(rd_val, 32'hf194);
    rd(BPE_OFS_IRQ_STAT);
    check(rd_val, 32'h3);
    chk_irq(1'b0);
    wr(BPE_OFS_IRQ_MASK, 32'h3);
    chk_irq(1'b1);
    wr(BPE_OFS_IRQ_STAT, 32'h1);
    rd(BPE_OFS_IRQ_STAT);
    check(rd_val, 32'h2);
    wr(BPE_OFS_IRQ_MASK, 32'h1);
    chk_irq(1'b0);
    wr(BPE_OFS_IRQ_STAT, 32'h2);
    conv(16'h0000, 16'hf19f, 1'b0);
    chk_irq(1'b1);
    wr(BPE_OFS_IRQ_MASK, 32'h0);
    chk_irq(1'b0);
    rd(8'h40);
    check({rd_val[30:0], rd_err}, 32'h1);
    wr(8'h18, 32'hffff);
    rd(8'h05);
    check({31'h0, rd_err}, 32'h1);
    rd(8'h81);
    check({rd_val[30:0], rd_err}, 32'h1);
    finish_test();
  end
endmodule
